/* File: design/lab_pkg.sv */
// constants, enumerations and carriers of the logic, average and branch datapath
package lab_pkg;

   localparam int WORD_W     = 32;
   localparam int REG_IDX_W  = 5;
   localparam int CST5_W     = 5;
   localparam int CST10_W    = 10;
   localparam int HALF_W     = 16;
   localparam int BYTE_W     = 8;
   localparam int UNITS_PER_SIDE = 4;
   localparam int DISP_SHIFT = 2;

   // cycle figures
   localparam int AND_LATENCY    = 1;
   localparam int AVG_LATENCY    = 2;
   localparam int BR_DELAY_SLOTS = 5;

   // values after reset
   localparam logic [31:0] FETCH_RST = 32'h0000_0000;
   localparam logic [31:0] WORD_RST  = 32'h0000_0000;

   typedef enum logic [1:0] {
      LAB_UNIT_LOGIC,
      LAB_UNIT_SHIFT,
      LAB_UNIT_DATA,
      LAB_UNIT_MULT
   } lab_unit_e;

   typedef enum logic [2:0] {
      LAB_OP_NONE,
      LAB_OP_AND_REG,
      LAB_OP_AND_CST,
      LAB_OP_AND_INV,
      LAB_OP_AVG_HALVES,
      LAB_OP_AVG_BYTES,
      LAB_OP_BR_DEC
   } lab_op_e;

   // one instruction presented to one functional unit slot
   typedef struct packed {
      logic                 valid;
      lab_op_e              op;
      logic                 pred_true;
      logic [REG_IDX_W-1:0] dst;
      logic [WORD_W-1:0]    src1;
      logic [WORD_W-1:0]    src2;
      logic [CST5_W-1:0]    short_signed_constant;
      logic [CST10_W-1:0]   branch_offset_constant;
      logic [WORD_W-1:0]    fetch_packet_address;
   } lab_issue_s;

   // destination register write
   typedef struct packed {
      logic                 valid;
      logic [REG_IDX_W-1:0] dst;
      logic [WORD_W-1:0]    data;
   } lab_wb_s;

   typedef struct packed {
      logic              valid;
      logic [WORD_W-1:0] target;
   } lab_branch_s;

endpackage

/* File: design/lab_datapath.sv */
// execution datapath for logic, averaging and branch-and-decrement instructions
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - short_signed_constant is sign-extended to 32 bits before the AND.
// RL2 - and_with_inverse writes src1 AND NOT src2 to the destination.
// RL3 - and_with_inverse runs on logic, data or shift unit of either side.
// RL4 - all three AND forms write the destination one cycle after issue.
// RL5 - average_signed_halves works on two independent 16-bit lanes.
// RL6 - each signed lane result is (a + b + 1) shifted right one bit.
// RL7 - each signed lane result lands in the lane it came from.
// RL8 - averages raise no overflow; the sum is kept one bit wider.
// RL9 - average_unsigned_bytes works on four unsigned 8-bit lanes.
// RL10 - each byte lane result is (a + b + 1) shifted right one bit.
// RL11 - averages run only on multiply units and write after two cycles.
// RL12 - branch_and_decrement branches only when the counter is at least zero.
// RL13 - non-negative counter: branch and decrement; otherwise nothing changes.
// RL14 - displacement is the sign-extended 10-bit branch_offset_constant.
// RL15 - target is displacement shifted left two plus fetch_packet_address.
// RL16 - the target is loaded into fetch_counter.
// RL17 - any general register may be the counter.
// RL18 - with a predicate, branch and decrement need predicate and counter both.
// RL19 - dispatch never presents two branch_and_decrement in one cycle.
// RL20 - code never puts two possibly taken branches in one execute packet.
// RL21 - branch_and_decrement runs only on the shift unit of either side.
// RL22 - a false predicate makes the instruction a no-operation.
// RL23 - decrement is written in the first stage; target after five delay slots.
module lab_datapath #(
   parameter int NUM_SIDES = 2
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   // issue slots, index side * 4 + unit
   input  wire lab_pkg::lab_issue_s [NUM_SIDES*lab_pkg::UNITS_PER_SIDE-1:0] issue,
   // destination writes per slot
   output lab_pkg::lab_wb_s         [NUM_SIDES*lab_pkg::UNITS_PER_SIDE-1:0] wb,
   // instruction refused by the unit it was sent to
   output logic                     [NUM_SIDES*lab_pkg::UNITS_PER_SIDE-1:0] bad_unit,
   // fetch redirection
   output logic                   [lab_pkg::WORD_W-1:0] fetch_counter,
   output logic                                         fetch_redirect
);

   localparam int SLOTS = NUM_SIDES * lab_pkg::UNITS_PER_SIDE;
   localparam int W     = lab_pkg::WORD_W;

   // which unit kinds may carry each operation
   function automatic logic unit_ok(input lab_pkg::lab_op_e op, input lab_pkg::lab_unit_e u);
      logic ok;
      ok = 1'b0;
      case (op)
         lab_pkg::LAB_OP_AND_REG,
         lab_pkg::LAB_OP_AND_CST,
         lab_pkg::LAB_OP_AND_INV: ok = (u != lab_pkg::LAB_UNIT_MULT);        // [RL3]
         lab_pkg::LAB_OP_AVG_HALVES,
         lab_pkg::LAB_OP_AVG_BYTES: ok = (u == lab_pkg::LAB_UNIT_MULT);      // [RL11]
         lab_pkg::LAB_OP_BR_DEC: ok = (u == lab_pkg::LAB_UNIT_SHIFT);       // [RL21]
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // signed halfword lanes; the extra sum bit keeps the halved result in range
   function automatic logic [W-1:0] avg_halves(input logic [W-1:0] a, input logic [W-1:0] b);
      logic [W-1:0]              r;
      logic signed [lab_pkg::HALF_W:0] s;
      r = lab_pkg::WORD_RST;
      for (int k = 0; k < W / lab_pkg::HALF_W; k++) begin                   // [RL5]
         s = $signed({a[k*lab_pkg::HALF_W+lab_pkg::HALF_W-1], a[k*lab_pkg::HALF_W +: lab_pkg::HALF_W]})
           + $signed({b[k*lab_pkg::HALF_W+lab_pkg::HALF_W-1], b[k*lab_pkg::HALF_W +: lab_pkg::HALF_W]})
           + 17'sh0_0001;                                                   // [RL6] [RL8]
         r[k*lab_pkg::HALF_W +: lab_pkg::HALF_W] = s[lab_pkg::HALF_W:1];    // [RL7]
      end
      return r;
   endfunction

   // unsigned byte lanes, nine-bit sum so the carry is never lost
   function automatic logic [W-1:0] avg_bytes(input logic [W-1:0] a, input logic [W-1:0] b);
      logic [W-1:0]              r;
      logic [lab_pkg::BYTE_W:0]  s;
      r = lab_pkg::WORD_RST;
      for (int k = 0; k < W / lab_pkg::BYTE_W; k++) begin                   // [RL9]
         s = {1'b0, a[k*lab_pkg::BYTE_W +: lab_pkg::BYTE_W]}
           + {1'b0, b[k*lab_pkg::BYTE_W +: lab_pkg::BYTE_W]} + 9'h001;      // [RL10] [RL8]
         r[k*lab_pkg::BYTE_W +: lab_pkg::BYTE_W] = s[lab_pkg::BYTE_W:1];
      end
      return r;
   endfunction

   // per-slot branch requests, gathered for the single branch pipe
   logic [SLOTS-1:0]  br_fire;
   logic [W-1:0]      br_tgt [SLOTS];

   genvar gs;
   generate
      for (gs = 0; gs < SLOTS; gs++) begin : g_slot
         localparam lab_pkg::lab_unit_e UNIT =
            lab_pkg::lab_unit_e'(gs % lab_pkg::UNITS_PER_SIDE);

         lab_pkg::lab_issue_s in;
         logic                legal;
         logic                exec;
         logic [W-1:0]        cst_ext;
         logic [W-1:0]        disp;
         logic                ctr_pos;
         logic                is_br;
         logic                is_avg;
         logic [W-1:0]        logic_res;
         lab_pkg::lab_wb_s    wb_d;

         assign in      = issue[gs];
         assign legal   = in.valid && unit_ok(in.op, UNIT);
         // a false predicate turns the slot into a no-operation
         assign exec    = legal && in.pred_true;                            // [RL22] [RL18]
         assign cst_ext = {{(W-lab_pkg::CST5_W){in.short_signed_constant[lab_pkg::CST5_W-1]}},
                           in.short_signed_constant};                       // [RL1]
         assign disp    = {{(W-lab_pkg::CST10_W){in.branch_offset_constant[lab_pkg::CST10_W-1]}},
                           in.branch_offset_constant};                      // [RL14]
         // src2 carries the counter register, whichever register it is
         assign ctr_pos = !in.src2[W-1];                                    // [RL12] [RL17]
         assign is_br   = in.op == lab_pkg::LAB_OP_BR_DEC;
         assign is_avg  = (in.op == lab_pkg::LAB_OP_AVG_HALVES)
                       || (in.op == lab_pkg::LAB_OP_AVG_BYTES);

         assign logic_res = (in.op == lab_pkg::LAB_OP_AND_CST) ? (cst_ext & in.src2)  // [RL1]
                          : (in.op == lab_pkg::LAB_OP_AND_INV) ? (in.src1 & ~in.src2) // [RL2]
                          : (in.src1 & in.src2);

         assign br_fire[gs] = exec && is_br && ctr_pos;                     // [RL13] [RL18]
         assign br_tgt[gs]  = in.fetch_packet_address + (disp << lab_pkg::DISP_SHIFT); // [RL15]

         if (UNIT == lab_pkg::LAB_UNIT_MULT) begin : g_mult
            // first execute stage holds the lane result, second writes it
            lab_pkg::lab_wb_s e1_q;
            lab_pkg::lab_wb_s e1_d;

            assign e1_d.valid = exec && is_avg;
            assign e1_d.dst   = in.dst;
            assign e1_d.data  = (in.op == lab_pkg::LAB_OP_AVG_BYTES)
                              ? avg_bytes(in.src1, in.src2) : avg_halves(in.src1, in.src2);
            assign wb_d       = e1_q;

            always_ff @(posedge ref_clk) begin
               if (!rstn) begin
                  e1_q <= '0;
               end else begin
                  e1_q <= e1_d;                                             // [RL11]
               end
            end
         end else begin : g_single
            // decrement lands in the first execute stage, like the AND results
            assign wb_d.valid = exec && (!is_br || ctr_pos);                // [RL4] [RL13] [RL23]
            assign wb_d.dst   = in.dst;
            assign wb_d.data  = is_br ? (in.src2 - 32'h0000_0001) : logic_res;
         end

         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               wb[gs]       <= '0;
               bad_unit[gs] <= 1'b0;
            end else begin
               wb[gs]       <= wb_d;
               bad_unit[gs] <= in.valid && !unit_ok(in.op, UNIT);
            end
         end
      end
   endgenerate

   // lowest slot wins if dispatch ever breaks the one-branch limit
   lab_pkg::lab_branch_s br_pick;
   logic [SLOTS:0]       br_seen;
   logic [W-1:0]         br_sel [SLOTS+1];

   assign br_seen[0] = 1'b0;
   assign br_sel[0]  = lab_pkg::WORD_RST;

   genvar gp;
   generate
      for (gp = 0; gp < SLOTS; gp++) begin : g_pick
         assign br_seen[gp+1] = br_seen[gp] || br_fire[gp];                 // [RL19] [RL20]
         assign br_sel[gp+1]  = (!br_seen[gp] && br_fire[gp]) ? br_tgt[gp] : br_sel[gp];
      end
   endgenerate

   assign br_pick.valid  = br_seen[SLOTS];
   assign br_pick.target = br_sel[SLOTS];

   // delay line for the branch shadow
   lab_pkg::lab_branch_s br_pipe_q [lab_pkg::BR_DELAY_SLOTS];
   lab_pkg::lab_branch_s br_last;

   assign br_last = br_pipe_q[lab_pkg::BR_DELAY_SLOTS-1];

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         for (int k = 0; k < lab_pkg::BR_DELAY_SLOTS; k++) begin
            br_pipe_q[k] <= '0;
         end
      end else begin
         br_pipe_q[0] <= br_pick;
         for (int k = 1; k < lab_pkg::BR_DELAY_SLOTS; k++) begin
            br_pipe_q[k] <= br_pipe_q[k-1];                                 // [RL23]
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         fetch_counter  <= lab_pkg::FETCH_RST;
         fetch_redirect <= 1'b0;
      end else begin
         fetch_redirect <= br_last.valid;
         if (br_last.valid) begin
            fetch_counter <= br_last.target;                                // [RL16]
         end
      end
   end

endmodule // lab_datapath

/* File: tb/lab_datapath_checker.sv */
// port-level assertions for the datapath
`timescale 1ns/1ps
module lab_checker #(
   parameter int NUM_SIDES = 2
) (
   // clock and reset
   input wire logic                             ref_clk,
   input wire logic                             rstn,
   // datapath ports
   input wire lab_pkg::lab_issue_s [NUM_SIDES*4-1:0] issue,
   input wire lab_pkg::lab_wb_s [NUM_SIDES*4-1:0]    wb,
   input wire logic [NUM_SIDES*4-1:0]                bad_unit,
   input wire logic [31:0]                           fetch_counter,
   input wire logic                                  fetch_redirect
);
   function automatic logic [15:0] hv(logic [15:0] a, logic [15:0] b);
      logic [16:0] s;
      s = {a[15], a} + {b[15], b} + 17'h1;
      return s[16:1];
   endfunction
   function automatic logic [7:0] bv(logic [7:0] a, logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b} + 9'h1;
      return s[8:1];
   endfunction
   wire lab_pkg::lab_issue_s i0 = issue[0];
   wire lab_pkg::lab_issue_s i1 = issue[1];
   wire lab_pkg::lab_issue_s i3 = issue[3];
   wire lab_pkg::lab_issue_s i7 = issue[7];
   wire v0 = i0.valid && i0.pred_true;
   wire [31:0] cx2 = {{27{issue[2].short_signed_constant[4]}},
      issue[2].short_signed_constant} & issue[2].src2;
   wire [31:0] avh = {hv(i3.src1[31:16], i3.src2[31:16]), hv(i3.src1[15:0], i3.src2[15:0])};
   wire [31:0] avb = {bv(i7.src1[31:24], i7.src2[31:24]), bv(i7.src1[23:16], i7.src2[23:16]),
      bv(i7.src1[15:8], i7.src2[15:8]), bv(i7.src1[7:0], i7.src2[7:0])};
   wire bd1 = i1.valid && i1.op == lab_pkg::LAB_OP_BR_DEC;
   wire br1 = bd1 && i1.pred_true && !i1.src2[31];
   wire br5 = issue[5].valid && issue[5].op == lab_pkg::LAB_OP_BR_DEC
      && issue[5].pred_true && !issue[5].src2[31];
   wire brt = br1 || br5;
   wire [31:0] tgt1 = i1.fetch_packet_address
      + {{20{i1.branch_offset_constant[9]}}, i1.branch_offset_constant, 2'b00};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   chk_inv_result: assert property (v0 && i0.op == lab_pkg::LAB_OP_AND_INV |=>
      wb[0].valid && wb[0].data == ($past(i0.src1) & ~$past(i0.src2)))
      else $error("and_with_inverse result wrong");
   chk_cst_result: assert property (issue[2].valid && issue[2].pred_true
      && issue[2].op == lab_pkg::LAB_OP_AND_CST |=> wb[2].valid && wb[2].data == $past(cx2))
      else $error("short constant AND result wrong");
   chk_half_avg: assert property (i3.valid && i3.pred_true
      && i3.op == lab_pkg::LAB_OP_AVG_HALVES |-> ##2 wb[3].valid && wb[3].data == $past(avh, 2))
      else $error("halfword average wrong");
   chk_byte_avg: assert property (i7.valid && i7.pred_true
      && i7.op == lab_pkg::LAB_OP_AVG_BYTES |-> ##2 wb[7].valid && wb[7].data == $past(avb, 2))
      else $error("byte average wrong");
   chk_unit_refuse: assert property (i0.valid && i0.op inside {lab_pkg::LAB_OP_AVG_HALVES,
      lab_pkg::LAB_OP_AVG_BYTES, lab_pkg::LAB_OP_BR_DEC} |=> bad_unit[0] && !wb[0].valid)
      else $error("op accepted on wrong unit");
   chk_pred_nop: assert property (i0.valid && !i0.pred_true |=> !wb[0].valid)
      else $error("false predicate wrote a result");
   chk_br_dec: assert property (br1 |=> wb[1].valid && wb[1].data == $past(i1.src2) - 32'h1)
      else $error("counter decrement wrong");
   chk_neg_hold: assert property (bd1 && i1.src2[31] |=> !wb[1].valid)
      else $error("negative counter was written");
   chk_br_target: assert property (br1 |-> ##6 fetch_redirect && fetch_counter == $past(tgt1, 6))
      else $error("branch target or timing wrong");
   chk_br_cause: assert property (fetch_redirect |-> $past(brt, 6))
      else $error("redirect without a taken branch");
endmodule // lab_checker
bind lab_datapath lab_checker #(.NUM_SIDES(NUM_SIDES)) u_chk (.ref_clk(ref_clk), .rstn(rstn),
   .issue(issue), .wb(wb), .bad_unit(bad_unit), .fetch_counter(fetch_counter),
   .fetch_redirect(fetch_redirect));

/* File: tb/lab_dispatch_model.sv */
// dispatch stand-in: presents at most one instruction a cycle
`timescale 1ns/1ps
module lab_dispatch_model (
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rstn,
   // request from the bench
   input wire lab_pkg::lab_issue_s   req,
   input wire logic [2:0]            req_slot,
   // toward the datapath
   output lab_pkg::lab_issue_s [7:0] issue
);
   // a single request a cycle, so no two branches ever share a packet
   always_ff @(posedge ref_clk) begin
      issue <= '0;
      if (rstn && req.valid) issue[req_slot] <= req;
   end
endmodule // lab_dispatch_model

/* File: tb/lab_datapath_tb.sv */
// self-checking bench for the logic, average and branch datapath
`timescale 1ns/1ps
module lab_datapath_tb;
   logic                     ref_clk = 1'b0;
   logic                     rstn = 1'b0;
   lab_pkg::lab_issue_s      req = '0;
   logic [2:0]               req_slot = 3'h0;
   lab_pkg::lab_issue_s [7:0] issue;
   lab_pkg::lab_wb_s [7:0]   wb;
   logic [7:0]               bad_unit;
   logic [31:0]              fetch_counter;
   logic                     fetch_redirect;
   int                       bad_count = 0;
   int                       n_checks = 0;
   int                       cycles = 0;
   always #2.5 ref_clk = ~ref_clk;
   lab_dispatch_model dsp (.ref_clk(ref_clk), .rstn(rstn), .req(req), .req_slot(req_slot),
      .issue(issue));
   lab_datapath #(.NUM_SIDES(2)) uut (.ref_clk(ref_clk), .rstn(rstn), .issue(issue), .wb(wb),
      .bad_unit(bad_unit), .fetch_counter(fetch_counter), .fetch_redirect(fetch_redirect));
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   function automatic lab_pkg::lab_issue_s mk(lab_pkg::lab_op_e op, logic p,
      logic [31:0] a, logic [31:0] b, logic [9:0] k);
      mk = '0;
      mk.valid = 1'b1;
      mk.op = op;
      mk.pred_true = p;
      mk.dst = 5'h0A;
      mk.src1 = a;
      mk.src2 = b;
      mk.short_signed_constant = k[4:0];
      mk.branch_offset_constant = k;
      mk.fetch_packet_address = 32'h0100_0000;
   endfunction
   // the datapath takes the instruction one edge after req; returns lat cycles later
   task automatic go(int s, lab_pkg::lab_issue_s ins, int lat);
      req_slot = 3'(s);
      req = ins;
      @(posedge ref_clk);
      #1;
      req = '0;
      repeat (lat) @(posedge ref_clk);
      #1;
   endtask
   task automatic t_and();
      int sl[6] = '{0, 1, 2, 4, 5, 6};
      foreach (sl[i]) begin
         go(sl[i], mk(lab_pkg::LAB_OP_AND_INV, 1'b1, 32'h1957_21AB, 32'h081C_17E6, 10'h0), 1);
         chk(wb[sl[i]].data, 32'h1143_2009);
      end
      go(2, mk(lab_pkg::LAB_OP_AND_CST, 1'b1, 32'h0, 32'h32E4_6936, 10'h011), 1);
      chk(wb[2].data, 32'h32E4_6930);
      go(0, mk(lab_pkg::LAB_OP_AND_REG, 1'b1, 32'hF7A1_302A, 32'h02B6_E724, 10'h0), 1);
      chk({26'h0, wb[0].valid, wb[0].dst}, 32'h2A);
      chk(wb[0].data, 32'h02A0_2020);
      go(0, mk(lab_pkg::LAB_OP_AND_INV, 1'b0, 32'hFFFF_FFFF, 32'h0, 10'h0), 1);
      chk({31'h0, wb[0].valid}, 32'h0);
      go(0, mk(lab_pkg::LAB_OP_AVG_HALVES, 1'b1, 32'h1, 32'h1, 10'h0), 1);
      chk({31'h0, bad_unit[0]}, 32'h1);
      go(4, mk(lab_pkg::LAB_OP_BR_DEC, 1'b1, 32'h0, 32'h3, 10'h0), 1);
      chk({31'h0, bad_unit[4]}, 32'h1);
   endtask
   task automatic t_avg();
      logic [31:0] a[4] = '{32'h6198_4357, 32'h7FFF_8000, 32'h1A2E_5F4E, 32'hFFFF_FFFF};
      logic [31:0] b[4] = '{32'h7582_AE15, 32'h7FFF_7FFF, 32'h9EF2_6E3F, 32'hFFFF_0000};
      logic [31:0] e[4] = '{32'h6B8D_F8B6, 32'h7FFF_0000, 32'h5C90_6747, 32'hFFFF_8080};
      lab_pkg::lab_op_e op;
      foreach (a[i]) begin
         if (i < 2) op = lab_pkg::LAB_OP_AVG_HALVES;
         else op = lab_pkg::LAB_OP_AVG_BYTES;
         go(i < 2 ? 3 : 7, mk(op, 1'b1, a[i], b[i], 10'h0), 2);
         chk(wb[i < 2 ? 3 : 7].data, e[i]);
      end
   endtask
   task automatic t_br(int s, logic [31:0] cnt, logic [9:0] off, logic p, logic [31:0] tgt);
      logic tk;
      tk = p && !cnt[31];
      go(s, mk(lab_pkg::LAB_OP_BR_DEC, p, 32'h0, cnt, off), 1);
      chk({31'h0, wb[s].valid}, {31'h0, tk});
      if (tk) chk(wb[s].data, cnt - 32'h1);
      repeat (5) @(posedge ref_clk);
      #1;
      chk({31'h0, fetch_redirect}, {31'h0, tk});
      chk(fetch_counter, tgt);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // the whole run needs fewer than a hundred cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(fetch_counter, lab_pkg::FETCH_RST);
      t_and();
      t_avg();
      t_br(1, 32'hA, 10'h100, 1'b1, 32'h0100_0400);
      t_br(5, 32'h0, 10'h300, 1'b1, 32'h00FF_FC00);
      t_br(1, 32'h8000_0000, 10'h100, 1'b1, 32'h00FF_FC00);
      t_br(5, 32'h5, 10'h100, 1'b0, 32'h00FF_FC00);
      final_report();
   end
endmodule // lab_datapath_tb
